//--- rtl/nco_pkg.sv
/*
 * Shared constants of the phase accumulator oscillator: register byte
 * offsets, field positions, reset values and the bus answer states.
 * Assumes a byte-addressed register bus with one 32-bit word a register.
 */
package nco_pkg;
  localparam int ACC_W = 20;
  localparam int UPPER_W = 4;
  localparam int PWS_W = 3;
  localparam int CKS_W = 4;
  localparam int N_SOURCES = 11;
  localparam int ADDR_W = 6;
  // register byte offsets
  localparam logic [5:0] OFF_CONTROL = 6'h00;
  localparam logic [5:0] OFF_CLK_SEL = 6'h04;
  localparam logic [5:0] OFF_ACC_LOW = 6'h08;
  localparam logic [5:0] OFF_ACC_HIGH = 6'h0C;
  localparam logic [5:0] OFF_ACC_UPPER = 6'h10;
  localparam logic [5:0] OFF_INC_LOW = 6'h14;
  localparam logic [5:0] OFF_INC_HIGH = 6'h18;
  localparam logic [5:0] OFF_INC_UPPER = 6'h1C;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h20;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h24;
  // field positions
  localparam int CTL_EN = 7;
  localparam int CTL_OUT = 5;
  localparam int CTL_POL = 4;
  localparam int CTL_PFM = 0;
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;
  localparam int IRQ_OVF = 0;
  // values after reset
  localparam logic [7:0] INC_LOW_RESET = 8'h01;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [19:0] SHADOW_RESET = 20'h00001;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_e;
endpackage : nco_pkg

//--- rtl/nco_link_if.sv
/*
 * Signals between the register side of the oscillator and its core.
 * Assumes both ends share clk and arst_n.
 */
`timescale 1ns/1ns
interface nco_link_if;
  logic run;
  logic pfm;
  logic [2:0] pws;
  logic rise;
  logic fall;
  logic [19:0] inc_value;
  logic inc_commit;
  logic [2:0] acc_wr_sel;
  logic [7:0] wr_byte;
  logic [19:0] acc;
  logic raw_out;
  logic carry;
  modport ctrl (output run, pfm, pws, rise, fall, inc_value, inc_commit,
    acc_wr_sel, wr_byte, input acc, raw_out, carry);
  modport core (input run, pfm, pws, rise, fall, inc_value, inc_commit,
    acc_wr_sel, wr_byte, output acc, raw_out, carry);
endinterface : nco_link_if

//--- rtl/edge_sync.sv
/*
 * Two-flop synchroniser for a vector of unrelated levels.
 * Assumes each bit changes slower than clk; bits are not coherent.
 */
`timescale 1ns/1ns
module edge_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : edge_sync

//--- rtl/nco_core.sv
/*
 * Accumulator, increment shadow and output shaper of the oscillator.
 * Assumes rise and fall are one-cycle pulses of the chosen source clock.
 */
`timescale 1ns/1ns
module nco_core (
  input wire logic clk,
  input wire logic arst_n,
  nco_link_if.core link
);
  logic [19:0] acc_ff;
  logic [19:0] shadow_ff;
  logic pend_ff;
  logic raw_ff;
  logic carry_ff;
  logic [7:0] width_ff;
  logic [20:0] sum;
  logic ovf;
  logic acc_wr;

  assign sum = {1'b0, acc_ff} + {1'b0, shadow_ff};
  assign acc_wr = |link.acc_wr_sel;
  assign ovf = link.run && link.rise && sum[20] && !acc_wr;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_ff <= '0;
      carry_ff <= 1'b0;
    end else begin
      carry_ff <= ovf;
      if (acc_wr) begin
        if (link.acc_wr_sel[0]) acc_ff[7:0] <= link.wr_byte;
        if (link.acc_wr_sel[1]) acc_ff[15:8] <= link.wr_byte;
        if (link.acc_wr_sel[2]) acc_ff[19:16] <= link.wr_byte[3:0];
      end else if (link.run && link.rise) begin
        acc_ff <= sum[19:0];
      end
    end
  end

  // commit waits for a falling source edge; immediate while stopped
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_ff <= 1'b0;
      shadow_ff <= nco_pkg::SHADOW_RESET;
    end else if (link.inc_commit) begin
      pend_ff <= 1'b1;
    end else if (pend_ff && (!link.run || link.fall)) begin
      pend_ff <= 1'b0;
      shadow_ff <= link.inc_value;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      raw_ff <= 1'b0;
      width_ff <= '0;
    end else if (!link.run) begin
      raw_ff <= 1'b0;
      width_ff <= '0;
    end else if (ovf) begin
      raw_ff <= link.pfm ? 1'b1 : !raw_ff;
      width_ff <= 8'h01 << link.pws;
    end else if (link.rise && link.pfm && raw_ff) begin
      raw_ff <= (width_ff > 8'h01);
      width_ff <= (width_ff > 8'h01) ? width_ff - 8'h01 : 8'h00;
    end
  end

  assign link.acc = acc_ff;
  assign link.raw_out = raw_ff;
  assign link.carry = carry_ff;

  acc_add_a: assert property (@(posedge clk) disable iff (!arst_n)
    link.run && link.rise && !acc_wr |=> acc_ff == $past(sum[19:0]))
    else $error("accumulator did not add the shadow increment");
  fdc_toggle_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf && !link.pfm |=> raw_ff != $past(raw_ff))
    else $error("fixed duty output did not toggle on carry");
  pulse_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    link.rise && !ovf && link.run && link.pfm && raw_ff
    && width_ff == 8'h01 |=> !raw_ff)
    else $error("pulse outlived its last source period");
  pulse_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    ovf && link.pfm |=> raw_ff && width_ff == (8'h01 << $past(link.pws)))
    else $error("pulse did not start with the selected width");
  shadow_load_a: assert property (@(posedge clk) disable iff (!arst_n)
    pend_ff && link.run && link.fall && !link.inc_commit
    |=> shadow_ff == $past(link.inc_value) && !pend_ff)
    else $error("shadow missed the falling source edge");
  carry_a: assert property (@(posedge clk) disable iff (!arst_n)
    link.run && link.rise && !acc_wr && sum[20] |=> carry_ff)
    else $error("carry out of bit 19 not flagged");
endmodule : nco_core

//--- rtl/phase_accumulator_oscillator.sv
/*
 * Numerically controlled oscillator with a 20-bit phase accumulator,
 * Avalon-MM register slave with waitrequest, and a level interrupt.
 * Assumes source clocks are unrelated to clk and slower than clk/2.
 */
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module phase_accumulator_oscillator #(
  parameter int N_SRC = nco_pkg::N_SOURCES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N_SRC-1:0] source_clock_in,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic nco_out,
  output logic irq
);
  nco_link_if link ();

  logic [N_SRC-1:0] src_sync;
  logic src_sel;
  logic src_prev_ff;
  logic rise_ff;
  logic fall_ff;

  logic module_enable_bit_ff;
  logic output_invert_ff;
  logic pulse_mode_select_ff;
  logic [2:0] pulse_width_select_ff;
  logic [3:0] clock_source_select_ff;
  logic [7:0] inc_low_ff;
  logic [7:0] inc_high_ff;
  logic [3:0] inc_upper_ff;
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  logic output_state_ff;

  nco_pkg::bus_state_e state_ff;
  logic [31:0] rd_mux;
  logic bus_wr;
  logic lane0;
  logic [7:0] wbyte;
  logic flag_clr;

  edge_sync #(
    .W(N_SRC)
  ) u_src_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(source_clock_in),
    .sync_out(src_sync)
  );

  // reserved selections give a still clock
  always_comb begin
    src_sel = 1'b0;
    if (int'(clock_source_select_ff) < N_SRC) begin
      src_sel = src_sync[clock_source_select_ff];
    end
  end

  // source edges become one-cycle enables in the clk domain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      src_prev_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_sel;
      rise_ff <= src_sel && !src_prev_ff;
      fall_ff <= !src_sel && src_prev_ff;
    end
  end

  nco_core u_core (
    .clk(clk),
    .arst_n(arst_n),
    .link(link.core)
  );

  // bus access: request taken in idle, answered the next cycle
  assign lane0 = byteenable[0];
  assign wbyte = writedata[7:0];
  assign bus_wr = (state_ff == nco_pkg::BUS_ANSWER) && write && lane0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= nco_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= '0;
    end else begin
      case (state_ff)
        nco_pkg::BUS_IDLE: begin
          if (read || write) begin
            state_ff <= nco_pkg::BUS_ANSWER;
            waitrequest <= 1'b0;
            readdata <= read ? rd_mux : 32'h0000_0000;
          end
        end
        nco_pkg::BUS_ANSWER: begin
          state_ff <= nco_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
        default: begin
          state_ff <= nco_pkg::BUS_IDLE;
          waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (address == nco_pkg::OFF_CONTROL) begin
      rd_mux[nco_pkg::CTL_EN] = module_enable_bit_ff;
      rd_mux[nco_pkg::CTL_OUT] = output_state_ff;
      rd_mux[nco_pkg::CTL_POL] = output_invert_ff;
      rd_mux[nco_pkg::CTL_PFM] = pulse_mode_select_ff;
    end else if (address == nco_pkg::OFF_CLK_SEL) begin
      rd_mux[nco_pkg::CLK_PWS_LSB +: nco_pkg::PWS_W] = pulse_width_select_ff;
      rd_mux[nco_pkg::CLK_CKS_LSB +: nco_pkg::CKS_W] = clock_source_select_ff;
    end else if (address == nco_pkg::OFF_ACC_LOW) begin
      rd_mux[7:0] = link.acc[7:0];
    end else if (address == nco_pkg::OFF_ACC_HIGH) begin
      rd_mux[7:0] = link.acc[15:8];
    end else if (address == nco_pkg::OFF_ACC_UPPER) begin
      rd_mux[3:0] = link.acc[19:16];
    end else if (address == nco_pkg::OFF_INC_LOW) begin
      rd_mux[7:0] = inc_low_ff;
    end else if (address == nco_pkg::OFF_INC_HIGH) begin
      rd_mux[7:0] = inc_high_ff;
    end else if (address == nco_pkg::OFF_INC_UPPER) begin
      rd_mux[3:0] = inc_upper_ff;
    end else if (address == nco_pkg::OFF_IRQ_STATUS) begin
      rd_mux[nco_pkg::IRQ_OVF] = overflow_flag_ff;
    end else if (address == nco_pkg::OFF_IRQ_MASK) begin
      rd_mux[nco_pkg::IRQ_OVF] = overflow_irq_enable_ff;
    end
  end

  // control and clock select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_enable_bit_ff <= 1'b0;
      output_invert_ff <= 1'b0;
      pulse_mode_select_ff <= 1'b0;
      pulse_width_select_ff <= '0;
      clock_source_select_ff <= '0;
    end else if (bus_wr) begin
      if (address == nco_pkg::OFF_CONTROL) begin
        module_enable_bit_ff <= wbyte[nco_pkg::CTL_EN];
        output_invert_ff <= wbyte[nco_pkg::CTL_POL];
        pulse_mode_select_ff <= wbyte[nco_pkg::CTL_PFM];
      end else if (address == nco_pkg::OFF_CLK_SEL) begin
        pulse_width_select_ff <=
          wbyte[nco_pkg::CLK_PWS_LSB +: nco_pkg::PWS_W];
        clock_source_select_ff <=
          wbyte[nco_pkg::CLK_CKS_LSB +: nco_pkg::CKS_W];
      end
    end
  end

  // increment bytes; only the low byte commits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      inc_low_ff <= nco_pkg::INC_LOW_RESET;
      inc_high_ff <= nco_pkg::BYTE_RESET;
      inc_upper_ff <= nco_pkg::BYTE_RESET[3:0];
    end else if (bus_wr) begin
      if (address == nco_pkg::OFF_INC_LOW) begin
        inc_low_ff <= wbyte;
      end else if (address == nco_pkg::OFF_INC_HIGH) begin
        inc_high_ff <= wbyte;
      end else if (address == nco_pkg::OFF_INC_UPPER) begin
        inc_upper_ff <= wbyte[3:0];
      end
    end
  end

  assign link.run = module_enable_bit_ff;
  assign link.pfm = pulse_mode_select_ff;
  assign link.pws = pulse_width_select_ff;
  assign link.rise = rise_ff;
  assign link.fall = fall_ff;
  assign link.inc_value = {inc_upper_ff, inc_high_ff, inc_low_ff};
  assign link.inc_commit = bus_wr && (address == nco_pkg::OFF_INC_LOW);
  assign link.wr_byte = wbyte;
  // writes while running are accepted; the written byte wins and that cycle's addition and carry are skipped
  assign link.acc_wr_sel[0] = bus_wr && (address == nco_pkg::OFF_ACC_LOW);
  assign link.acc_wr_sel[1] = bus_wr && (address == nco_pkg::OFF_ACC_HIGH);
  assign link.acc_wr_sel[2] = bus_wr && (address == nco_pkg::OFF_ACC_UPPER);

  // sticky overflow flag, write one to clear, set wins
  assign flag_clr = bus_wr && (address == nco_pkg::OFF_IRQ_STATUS)
    && wbyte[nco_pkg::IRQ_OVF];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag_ff <= 1'b0;
    end else if (link.carry) begin
      overflow_flag_ff <= 1'b1;
    end else if (flag_clr) begin
      overflow_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_enable_ff <= 1'b0;
    end else if (bus_wr && (address == nco_pkg::OFF_IRQ_MASK)) begin
      overflow_irq_enable_ff <= wbyte[nco_pkg::IRQ_OVF];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= overflow_flag_ff && overflow_irq_enable_ff;
    end
  end

  // polarity is the last stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      output_state_ff <= 1'b0;
      nco_out <= 1'b0;
    end else begin
      output_state_ff <= link.raw_out ^ output_invert_ff;
      nco_out <= link.raw_out ^ output_invert_ff;
    end
  end

  sequence take_s;
    state_ff == nco_pkg::BUS_IDLE && (read || write);
  endsequence

  sequence answer_s;
    !waitrequest ##1 waitrequest;
  endsequence

  bus_answer_a: assert property (@(posedge clk) disable iff (!arst_n)
    take_s |=> answer_s)
    else $error("bus answer not one cycle after request");

  sequence read_acc_upper_s;
    take_s ##0 read && address == nco_pkg::OFF_ACC_UPPER;
  endsequence

  acc_upper_read_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    read_acc_upper_s |=> readdata[31:4] == 28'h0000000
    && readdata[3:0] == $past(link.acc[19:16]))
    else $error("upper accumulator byte read wrong");

  acc_high_read_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    take_s ##0 read && address == nco_pkg::OFF_ACC_HIGH
    |=> readdata == {24'h000000, $past(link.acc[15:8])})
    else $error("high accumulator byte read wrong");

  inc_upper_read_a: assert property (@(posedge clk)
    disable iff (!arst_n)
    take_s ##0 read && address == nco_pkg::OFF_INC_UPPER
    |=> readdata[31:4] == 28'h0000000)
    else $error("upper increment byte bits above 3 not zero");

  flag_set_a: assert property (@(posedge clk) disable iff (!arst_n)
    link.carry |=> overflow_flag_ff)
    else $error("overflow flag not set after carry");

  flag_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    overflow_flag_ff && !flag_clr |=> overflow_flag_ff)
    else $error("overflow flag dropped without a clear");

  irq_level_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 irq == $past(overflow_flag_ff && overflow_irq_enable_ff))
    else $error("interrupt output does not follow flag and mask");

  out_polarity_a: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 nco_out == ($past(link.raw_out) ^ $past(output_invert_ff)))
    else $error("output polarity stage wrong");
endmodule : phase_accumulator_oscillator

//--- tb/phase_accumulator_oscillator_bench.sv
/*
 * Self-checking bench for the phase accumulator oscillator: register
 * reset values, byte masks, increment shadow, fixed duty and pulse modes,
 * overflow interrupt. Assumes nco_pkg offsets and a 20 MHz clk.
 */
`timescale 1ns/1ns
module phase_accumulator_oscillator_bench;
  localparam int NS = nco_pkg::N_SOURCES;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [NS-1:0] src = '0;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic nco_out;
  logic irq;
  int n_errors = 0;
  int check_count = 0;
  logic [15:0] seed = 16'h000C;
  int val[8];
  int acc_m, inc_m, inc_w, ovf, sel, pol, pulse, hi;
  logic pend;
  logic [7:0] q;

  phase_accumulator_oscillator #(.N_SRC(NS)) DUT (
    .clk(clk), .arst_n(arst_n), .source_clock_in(src),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .nco_out(nco_out), .irq(irq));

  always #25 clk = ~clk;

  function automatic int rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return int'(seed);
  endfunction : rnd

  task automatic chk_reg(input string what, input int exp,
                         input logic [7:0] got);
    check_count++;
    if (got !== 8'(exp)) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, 8'(exp), got);
    end
  endtask : chk_reg

  task automatic chk_pin(input string what, input logic exp,
                         input logic got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_pin

  task automatic bus_acc(input logic [5:0] a, input logic wr_n_rd,
                         input logic [7:0] d, input logic be);
    @(posedge clk);
    address <= a;
    read <= ~wr_n_rd;
    write <= wr_n_rd;
    writedata <= {24'h000000, d};
    byteenable <= be ? 4'hF : 4'hE;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_acc

  task automatic wr(input logic [5:0] a, input int d);
    bus_acc(a, 1'b1, 8'(d), 1'b1);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] a, input int e);
    bus_acc(a, 1'b0, 8'h00, 1'b1);
    chk_reg(what, e, q);
  endtask : rdc

  // one source period; model adds on rise, commits shadow on fall
  task automatic src_edge();
    int sum;
    @(posedge clk);
    src <= NS'(rnd()) | (NS'(1) << sel);
    sum = acc_m + inc_m;
    if (sum >= 32'h00100000) ovf++;
    acc_m = sum & 32'h000FFFFF;
    repeat (8) @(posedge clk);
    if (pulse == 0) chk_pin("nco_out", 1'((ovf % 2) ^ pol), nco_out);
    else if ((nco_out ^ 1'(pol)) === 1'b1) hi++;
    src <= NS'(rnd()) & ~(NS'(1) << sel);
    if (pend) begin
      inc_m = inc_w;
      pend = 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask : src_edge

  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    // whole map including unmapped words
    for (int a = 0; a < 64; a += 4) begin
      rdc("reset value", 6'(a), (a == 20) ? 1 : 0);
    end
    // random bytes while disabled; upper bytes keep only bits 3..0
    for (int a = 8; a < 32; a += 4) begin
      val[a / 4] = rnd() & ((a == 16 || a == 28) ? 8'h0F : 8'hFF);
      wr(6'(a), ((a == 16 || a == 28) ? (rnd() & 8'hF0) : 0)
        | val[a / 4]);
      rdc("byte register", 6'(a), val[a / 4]);
    end
    bus_acc(nco_pkg::OFF_INC_HIGH, 1'b1, 8'(~val[6]), 1'b0);
    rdc("masked write", nco_pkg::OFF_INC_HIGH, val[6]);
    wr(6'h28, 8'hFF);
    rdc("unmapped", 6'h28, 0);
    sel = rnd() % NS;
    wr(nco_pkg::OFF_CLK_SEL, 8'hF0 | sel);
    rdc("clock select", nco_pkg::OFF_CLK_SEL, 8'hE0 | sel);
    // low byte went first, so only it reached the shadow
    acc_m = (val[4] << 16) | (val[3] << 8) | val[2];
    inc_m = val[5];
    pol = rnd() % 2;
    pulse = 0;
    pend = 1'b0;
    ovf = 0;
    wr(nco_pkg::OFF_CONTROL, 8'h80 | (pol << 4));
    repeat (4) src_edge();
    inc_w = ((3 + rnd() % 12) << 16) | (rnd() & 16'hFFFF);
    wr(nco_pkg::OFF_INC_UPPER, inc_w >> 16);
    wr(nco_pkg::OFF_INC_HIGH, (inc_w >> 8) & 8'hFF);
    repeat (2) src_edge();
    wr(nco_pkg::OFF_INC_LOW, inc_w & 8'hFF);
    pend = 1'b1;
    repeat (16) src_edge();
    rdc("control", nco_pkg::OFF_CONTROL,
      8'h80 | (pol << 4) | (((ovf % 2) ^ pol) << 5));
    rdc("acc low", nco_pkg::OFF_ACC_LOW, acc_m & 8'hFF);
    rdc("acc high", nco_pkg::OFF_ACC_HIGH, (acc_m >> 8) & 8'hFF);
    rdc("acc upper", nco_pkg::OFF_ACC_UPPER, acc_m >> 16);
    rdc("flag", nco_pkg::OFF_IRQ_STATUS, (ovf > 0) ? 1 : 0);
    chk_pin("irq masked", 1'b0, irq);
    wr(nco_pkg::OFF_IRQ_MASK, 1);
    repeat (3) @(posedge clk);
    chk_pin("irq", 1'b1, irq);
    wr(nco_pkg::OFF_IRQ_STATUS, 1);
    repeat (3) @(posedge clk);
    chk_pin("irq cleared", 1'b0, irq);
    rdc("flag cleared", nco_pkg::OFF_IRQ_STATUS, 0);
    wr(nco_pkg::OFF_CONTROL, pol << 4);
    repeat (3) @(posedge clk);
    chk_pin("idle output", 1'(pol), nco_out);
    // overflows at edges 4, 12, 20, 28 of each run
    for (int c = 0; c < 3; c++) begin
      wr(nco_pkg::OFF_ACC_LOW, 0);
      wr(nco_pkg::OFF_ACC_HIGH, 0);
      wr(nco_pkg::OFF_ACC_UPPER, 8);
      wr(nco_pkg::OFF_INC_UPPER, 2);
      wr(nco_pkg::OFF_INC_HIGH, 0);
      wr(nco_pkg::OFF_INC_LOW, 0);
      wr(nco_pkg::OFF_CLK_SEL, (c << 5) | sel);
      wr(nco_pkg::OFF_CONTROL, 8'h81 | (pol << 4));
      acc_m = 20'h80000;
      inc_m = 20'h20000;
      pulse = 1;
      hi = 0;
      repeat (32) src_edge();
      chk_reg("active periods", 4 << c, 8'(hi));
      wr(nco_pkg::OFF_CONTROL, 0);
    end
    rdc("acc after pulses", nco_pkg::OFF_ACC_UPPER, acc_m >> 16);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rdc("inc low reset", nco_pkg::OFF_INC_LOW, 1);
    rdc("acc upper reset", nco_pkg::OFF_ACC_UPPER, 0);
    chk_pin("irq reset", 1'b0, irq);
    end_sim();
  end
endmodule : phase_accumulator_oscillator_bench
